// ==== tmr_pkg.sv ====
// shared constants, field layout and types of the 16-bit multimode timer
package tmr_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMP = 8'h04;
  localparam logic [7:0] OFS_CAP = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // timer_control_reg layout
  localparam int CTRL_W = 11;
  localparam int CLK_LSB = 0;
  localparam int DIV2_BIT = 2;
  localparam int EDGE_RISE_BIT = 4;
  localparam int EDGE_FALL_BIT = 5;
  localparam int OPT_BIT = 6;
  localparam int RUN_BIT = 7;
  localparam int MODE_LSB = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [CTRL_W-1:0] CTRL_WMASK = 11'h7f7;
  // fields that only change while the counter is stopped
  localparam logic [CTRL_W-1:0] CTRL_LOCK = 11'h707;

  localparam logic [15:0] CMP_RST = 16'hffff;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  typedef enum logic [2:0] {
    MODE_TIMER = 3'h0,
    MODE_EXT = 3'h1,
    MODE_EVENT = 3'h2,
    MODE_WINDOW = 3'h3,
    MODE_PULSE = 3'h4
  } mode_t;

  typedef enum logic [2:0] {
    PH_STOP = 3'b001,
    PH_WAIT = 3'b010,
    PH_COUNT = 3'b100
  } phase_t;

  // prescaler: osc_clock is CLK_SYS itself
  localparam int PRESC_W = 12;
  localparam logic [PRESC_W-1:0] MASK_SEL0 = 12'h7ff;
  localparam logic [PRESC_W-1:0] MASK_SEL1 = 12'h07f;
  localparam logic [PRESC_W-1:0] MASK_SEL2 = 12'h007;

  // input noise filter, times in osc_clock periods
  localparam int REJECT_OSC = 7;
  localparam int ACCEPT_OSC = 13;
  localparam int SYS_PER_OSC = 1;
  localparam int FILT_CYCLES = (REJECT_OSC + 1) * SYS_PER_OSC;

  // tick period mask: 2^11, 2^7, 2^3 osc periods, doubled by div2
  function automatic logic [PRESC_W-1:0] period_mask(input logic [1:0] sel,
                                                     input logic div2);
    logic [PRESC_W-1:0] base;
    base = (sel == 2'h0) ? MASK_SEL0 : (sel == 2'h1) ? MASK_SEL1 : MASK_SEL2;
    return div2 ? {base[PRESC_W-2:0], 1'b1} : base;
  endfunction : period_mask

endpackage : tmr_pkg

// ==== timer_pin_filter.sv ====
// synchroniser, noise filter and edge detector for the timer input pin
`timescale 1ns/10ps
module timer_pin_filter #(
  parameter int FILT_CYCLES = tmr_pkg::FILT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic pin,
  output logic lvl,
  output logic rise,
  output logic fall
);
  import tmr_pkg::*;

  localparam int CW = $clog2(FILT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_CYCLES - 1);

  logic sync1_r;
  logic sync2_r;
  logic filt_r;
  logic prev_r;
  logic [CW-1:0] cnt_r;

  wire logic differs = sync2_r ^ filt_r;
  wire logic settle = differs & (cnt_r == LAST);

  // a level must differ for FILT_CYCLES clocks in a row before it is taken
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      filt_r <= 1'b0;
      prev_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      prev_r <= filt_r;
      cnt_r <= (differs & ~settle) ? cnt_r + CW'(1) : '0;
      if (settle) begin
        filt_r <= sync2_r;
      end
    end
  end

  assign lvl = filt_r;
  assign rise = filt_r & ~prev_r;
  assign fall = ~filt_r & prev_r;

endmodule : timer_pin_filter

// ==== multimode_timer_counter16.sv ====
// 16-bit five-mode timer/counter with apb register access
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module multimode_timer_counter16 (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_INPUT_PIN,
  output logic TIMER_MATCH_IRQ
);
  import tmr_pkg::*;

  logic [CTRL_W-1:0] ctrl_r;
  logic [15:0] cmp_r;
  logic [15:0] cap_r;
  logic [15:0] cap_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  phase_t phase_r;
  phase_t phase_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [PRESC_W-1:0] presc_r;
  logic [31:0] prdata_r;
  logic pin_lvl;
  logic pin_rise;
  logic pin_fall;

  timer_pin_filter #(
    .FILT_CYCLES(FILT_CYCLES)
  ) u_filter (
    .clk(CLK_SYS),
    .srst(SRST),
    .pin(TIMER_INPUT_PIN),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // apb decode; zero wait states, so pready is constant high
  wire logic access = PSEL & PENABLE;
  wire logic wr = access & PWRITE;
  wire logic rd_setup = PSEL & ~PENABLE & ~PWRITE;
  wire logic hit_ctrl = (PADDR == OFS_CTRL);
  wire logic hit_cmp = (PADDR == OFS_CMP);
  wire logic hit_cap = (PADDR == OFS_CAP);
  wire logic hit_cnt = (PADDR == OFS_CNT);
  wire logic hit_stat = (PADDR == OFS_STAT);
  wire logic mapped = hit_ctrl | hit_cmp | hit_cap | hit_cnt | hit_stat;
  wire logic wr_ctrl = wr & hit_ctrl;
  wire logic wr_cmp = wr & hit_cmp;

  // control fields
  wire logic run = ctrl_r[RUN_BIT];
  wire logic opt = ctrl_r[OPT_BIT];
  wire logic use_fall = ctrl_r[EDGE_FALL_BIT];
  wire mode_t mode_q = mode_t'(ctrl_r[MODE_LSB +: 3]);
  wire logic [CTRL_W-1:0] wdata = PWDATA[CTRL_W-1:0] & CTRL_WMASK;

  // while running, mode, source clock and div2 keep their old value
  wire logic [CTRL_W-1:0] ctrl_wv = run ? ((ctrl_r & CTRL_LOCK) | (wdata & ~CTRL_LOCK))
                                        : wdata;
  wire mode_t mode_w = mode_t'(ctrl_wv[MODE_LSB +: 3]);
  wire logic start = wr_ctrl & ~run & ctrl_wv[RUN_BIT];
  wire logic stop = wr_ctrl & run & ~ctrl_wv[RUN_BIT];

  // edge and gate polarity from bit 5 alone (bit 4 is unused): bit5 picks falling or low
  wire logic trig_edge = use_fall ? pin_fall : pin_rise;
  wire logic back_edge = use_fall ? pin_rise : pin_fall;
  wire logic gate_on = use_fall ? ~pin_lvl : pin_lvl;

  // prescaler is cleared only by SRST, never on start, so the first tick after start may be early
  wire logic [PRESC_W-1:0] tick_mask = period_mask(ctrl_r[CLK_LSB +: 2],
                                                   ctrl_r[DIV2_BIT]);
  wire logic tick = ((presc_r & tick_mask) == tick_mask);

  wire logic [15:0] cnt_inc = cnt_r + 16'h0001;
  wire logic hit = (cnt_inc == cmp_r);
  wire logic [15:0] cnt_wrap = hit ? 16'h0000 : cnt_inc;
  wire logic is_cap_mode = (mode_q == MODE_TIMER) | (mode_q == MODE_EVENT);
  wire logic sw_cap = wr_ctrl & PWDATA[OPT_BIT] & is_cap_mode;

  always_comb begin
    cnt_nxt = cnt_r;
    cap_nxt = cap_r;
    phase_nxt = phase_r;
    irq_nxt = 1'b0;
    if (sw_cap) begin
      cap_nxt = cnt_r;
    end
    if (start) begin
      cnt_nxt = 16'h0000;
      phase_nxt = (mode_w == MODE_EXT || mode_w == MODE_PULSE) ? PH_WAIT : PH_COUNT;
    end else if (!run || stop) begin
      phase_nxt = PH_STOP;
    end else begin
      case (mode_q)
        MODE_TIMER: begin
          if (tick) begin
            cnt_nxt = cnt_wrap;
            irq_nxt = hit;
          end
        end
        MODE_WINDOW: begin
          if (tick && gate_on) begin
            cnt_nxt = cnt_wrap;
            irq_nxt = hit;
          end
        end
        MODE_EVENT: begin
          if (trig_edge) begin
            cnt_nxt = cnt_inc;
          end else if (back_edge && cnt_r == cmp_r) begin
            cnt_nxt = 16'h0000;
            irq_nxt = 1'b1;
          end
        end
        MODE_EXT: begin
          if (phase_r == PH_WAIT) begin
            if (trig_edge) begin
              cnt_nxt = 16'h0000;
              phase_nxt = PH_COUNT;
            end
          end else if (opt && back_edge) begin
            cnt_nxt = 16'h0000;
            phase_nxt = PH_WAIT;
          end else if (tick) begin
            // trigger edges fall through here unused
            cnt_nxt = cnt_wrap;
            irq_nxt = hit;
            if (hit) begin
              phase_nxt = PH_WAIT;
            end
          end
        end
        MODE_PULSE: begin
          if (phase_r == PH_WAIT) begin
            if (trig_edge) begin
              phase_nxt = PH_COUNT;
            end
          end else if (back_edge) begin
            cap_nxt = cnt_r;
            irq_nxt = 1'b1;
            if (!opt) begin
              cnt_nxt = 16'h0001;
              phase_nxt = PH_WAIT;
            end
          end else if (opt && trig_edge) begin
            cap_nxt = cnt_r;
            irq_nxt = 1'b1;
          end else if (tick) begin
            cnt_nxt = cnt_inc;
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      presc_r <= '0;
      cnt_r <= CNT_RST;
      cap_r <= CAP_RST;
      phase_r <= PH_STOP;
      irq_r <= 1'b0;
    end else begin
      presc_r <= presc_r + PRESC_W'(1);
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
      phase_r <= phase_nxt;
      irq_r <= irq_nxt;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ctrl_r <= CTRL_RST;
      cmp_r <= CMP_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_wv;
      end
      if (wr_cmp) begin
        cmp_r <= PWDATA[15:0];
      end
    end
  end

  // read data is sampled in the setup cycle and stands through access
  wire logic [31:0] rd_mux = hit_ctrl ? {21'h000000, ctrl_r}
                           : hit_cmp ? {16'h0000, cmp_r}
                           : hit_cap ? {16'h0000, cap_r}
                           : hit_cnt ? {16'h0000, cnt_r}
                           : hit_stat ? {29'h00000000, phase_r}
                           : 32'h00000000;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      prdata_r <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;
  assign TIMER_MATCH_IRQ = irq_r;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  property p_timer_clear;
    irq_r && mode_q == MODE_TIMER && run |-> cnt_r == 16'h0000 && $past(cnt_inc) == $past(cmp_r);
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer match did not clear");

  // a control write may change the mask mid-period, so it drops the attempt
  property p_tick_spacing;
    disable iff (SRST || wr_ctrl)
    tick && run && ctrl_r[CLK_LSB +: 2] == 2'h2 && !ctrl_r[DIV2_BIT] && !wr_ctrl
      |=> !tick [*7] ##1 tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick period not 8");

  property p_sw_capture;
    sw_cap && !start |=> cap_r == $past(cnt_r);
  endproperty
  a_sw_capture: assert property (p_sw_capture) else $error("software capture lost");

  property p_ext_halt;
    irq_r && mode_q == MODE_EXT && run |-> phase_r == PH_WAIT && cnt_r == 16'h0000;
  endproperty
  a_ext_halt: assert property (p_ext_halt) else $error("trigger mode did not halt");

  property p_rev_stop;
    run && !wr_ctrl && mode_q == MODE_EXT && phase_r == PH_COUNT && opt && back_edge
      |=> phase_r == PH_WAIT && cnt_r == 16'h0000;
  endproperty
  a_rev_stop: assert property (p_rev_stop) else $error("reverse edge did not stop");

  property p_retrig_ignored;
    run && !wr_ctrl && mode_q == MODE_EXT && phase_r == PH_COUNT && trig_edge && !tick
      |=> cnt_r == $past(cnt_r) && phase_r == PH_COUNT;
  endproperty
  a_retrig_ignored: assert property (p_retrig_ignored) else $error("retrigger restarted");

  property p_event_match_edge;
    irq_r && mode_q == MODE_EVENT |-> $past(back_edge) && cnt_r == 16'h0000;
  endproperty
  a_event_match_edge: assert property (p_event_match_edge) else $error("event irq off edge");

  property p_window_gate;
    run && !wr_ctrl && mode_q == MODE_WINDOW && !gate_on |=> cnt_r == $past(cnt_r);
  endproperty
  a_window_gate: assert property (p_window_gate) else $error("window counted when closed");

  property p_pulse_single;
    run && !wr_ctrl && mode_q == MODE_PULSE && phase_r == PH_COUNT && back_edge && !opt
      |=> cnt_r == 16'h0001 && cap_r == $past(cnt_r) && irq_r && phase_r == PH_WAIT;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("single capture wrong");

  property p_lock_mode;
    wr_ctrl && run |=> (ctrl_r & CTRL_LOCK) == ($past(ctrl_r) & CTRL_LOCK);
  endproperty
  a_lock_mode: assert property (p_lock_mode) else $error("mode changed while running");

  property p_event_count;
    run && !wr_ctrl && mode_q == MODE_EVENT && trig_edge |=> cnt_r == $past(cnt_inc);
  endproperty
  a_event_count: assert property (p_event_count) else $error("event edge not counted");

  property p_event_quiet;
    run && mode_q == MODE_EVENT && !back_edge |=> !irq_r;
  endproperty
  a_event_quiet: assert property (p_event_quiet) else $error("event irq without edge");

  property p_window_count;
    run && !wr_ctrl && mode_q == MODE_WINDOW && gate_on && tick && !hit
      |=> cnt_r == $past(cnt_inc);
  endproperty
  a_window_count: assert property (p_window_count) else $error("window tick lost");

  property p_ext_idle;
    run && !wr_ctrl && mode_q == MODE_EXT && phase_r == PH_WAIT && !trig_edge
      |=> phase_r == PH_WAIT && cnt_r == $past(cnt_r);
  endproperty
  a_ext_idle: assert property (p_ext_idle) else $error("trigger mode ran untriggered");

  property p_ext_start;
    run && !wr_ctrl && mode_q == MODE_EXT && phase_r == PH_WAIT && trig_edge
      |=> phase_r == PH_COUNT && cnt_r == 16'h0000;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("trigger edge did not start");

  property p_pulse_start;
    run && !wr_ctrl && mode_q == MODE_PULSE && phase_r == PH_WAIT && trig_edge
      |=> phase_r == PH_COUNT && cnt_r == $past(cnt_r);
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse start missed");

  property p_pulse_double;
    run && !wr_ctrl && mode_q == MODE_PULSE && phase_r == PH_COUNT && opt
      && (back_edge || trig_edge) |=> irq_r && cap_r == $past(cnt_r) && phase_r == PH_COUNT;
  endproperty
  a_pulse_double: assert property (p_pulse_double) else $error("double capture wrong");

  property p_irq_single;
    irq_r |=> !irq_r;
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("irq wider than one cycle");

  property p_start_clear;
    start |=> cnt_r == 16'h0000 && phase_r != PH_STOP;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start did not clear");

endmodule : multimode_timer_counter16

// ==== tmr_pulse_src.sv ====
// pulse source model driving the timer input pin
`timescale 1ns/10ps
module tmr_pulse_src (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;
  // whole-cycle levels, long against the tick so gate counts stay readable
  task automatic drive(input logic lvl, input int n);
    pin <= lvl;
    repeat (n) @(posedge clk);
  endtask : drive
endmodule : tmr_pulse_src

// ==== multimode_timer_counter16_tb_top.sv ====
// self-checking testbench of the 16-bit multimode timer
`timescale 1ns/10ps
module multimode_timer_counter16_tb_top;
  import tmr_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic pin;
  wire logic irq;
  int errors = 0;
  int checked = 0;
  int irqs = 0;
  int n;
  int k;
  logic [31:0] v;
  logic [31:0] w;
  logic e;
  logic [7:0] ofs [5] = '{OFS_CTRL, OFS_CMP, OFS_CAP, OFS_CNT, OFS_STAT};
  logic [31:0] rv [5] = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'h1};

  multimode_timer_counter16 u_multimode_timer_counter16 (.CLK_SYS(clk_sys), .SRST(srst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TIMER_INPUT_PIN(pin),
    .TIMER_MATCH_IRQ(irq));
  tmr_pulse_src u_tmr_pulse_src (.clk(clk_sys), .pin(pin));

  initial forever #4 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (irq === 1'b1) irqs++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no own limit here: only the watchdog ends a hung access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wait_irq();
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    chk(32'(n < 3000), 32'h1);
    @(posedge clk_sys);
  endtask : wait_irq

  task automatic t_reset_map();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(v, rv[i]);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk(v, 32'h0);
    chk(32'(e), 32'h1);
  endtask : t_reset_map

  task automatic t_timer();
    apb(1'b1, OFS_CMP, 32'h3);
    apb(1'b1, OFS_CTRL, 32'h082);
    wait_irq();
    wait_irq();
    chk(n, 32'd24);
    apb(1'b1, OFS_CTRL, 32'h282);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(v, 32'h082);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h086);
    wait_irq();
    wait_irq();
    chk(n, 32'd48);
    apb(1'b1, OFS_CMP, 32'd100);
    wait_irq();
    repeat (80) @(posedge clk_sys);
    apb(1'b1, OFS_CTRL, 32'h0c6);
    // one tick of wait before reading the copy
    repeat (20) @(posedge clk_sys);
    apb(1'b0, OFS_CAP, 32'h0);
    chk(32'(v >= 4 && v <= 6), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CMP, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h081);
    wait_irq();
    wait_irq();
    chk(n, 32'd128);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h080);
    wait_irq();
    wait_irq();
    chk(n, 32'd2048);
  endtask : t_timer

  task automatic t_event();
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CMP, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h210);
    apb(1'b1, OFS_CTRL, 32'h290);
    u_tmr_pulse_src.drive(1'b1, 5);
    u_tmr_pulse_src.drive(1'b0, 30);
    u_tmr_pulse_src.drive(1'b1, 30);
    u_tmr_pulse_src.drive(1'b0, 30);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(v, 32'h1);
    k = irqs;
    u_tmr_pulse_src.drive(1'b1, 30);
    chk(32'(irqs - k), 32'h0);
    u_tmr_pulse_src.drive(1'b0, 30);
    chk(32'(irqs - k), 32'h1);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(v, 32'h0);
  endtask : t_event

  task automatic t_ext();
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CMP, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h112);
    apb(1'b1, OFS_CTRL, 32'h192);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(v, 32'h2);
    k = irqs;
    u_tmr_pulse_src.drive(1'b1, 60);
    chk(32'(irqs - k), 32'h1);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(v, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1d2);
    u_tmr_pulse_src.drive(1'b0, 20);
    u_tmr_pulse_src.drive(1'b1, 20);
    u_tmr_pulse_src.drive(1'b0, 50);
    chk(32'(irqs - k), 32'h1);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(v, 32'h2);
  endtask : t_ext

  task automatic t_pulse();
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h412);
    apb(1'b1, OFS_CTRL, 32'h492);
    k = irqs;
    u_tmr_pulse_src.drive(1'b1, 80);
    // 80 + 45 + 3 cycles keep both pulses on the same tick phase
    u_tmr_pulse_src.drive(1'b0, 45);
    // first copy is checked and kept in w, taken before the next trigger
    apb(1'b0, OFS_CAP, 32'h0);
    w = v;
    chk(32'(w >= 9 && w <= 11), 32'h1);
    u_tmr_pulse_src.drive(1'b1, 80);
    u_tmr_pulse_src.drive(1'b0, 40);
    apb(1'b0, OFS_CAP, 32'h0);
    chk(v, w + 32'h1);
    chk(32'(irqs - k), 32'h2);
    // double-edge capture on a falling trigger
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h4e2);
    k = irqs;
    u_tmr_pulse_src.drive(1'b1, 40);
    u_tmr_pulse_src.drive(1'b0, 80);
    u_tmr_pulse_src.drive(1'b1, 40);
    apb(1'b0, OFS_CAP, 32'h0);
    w = v;
    chk(32'(w >= 9 && w <= 11), 32'h1);
    u_tmr_pulse_src.drive(1'b0, 40);
    apb(1'b0, OFS_CAP, 32'h0);
    chk(32'(v >= w + 5 && v <= w + 6), 32'h1);
    chk(32'(irqs - k), 32'h2);
  endtask : t_pulse

  task automatic t_window();
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CMP, 32'h5);
    apb(1'b1, OFS_CTRL, 32'h322);
    u_tmr_pulse_src.drive(1'b1, 20);
    apb(1'b1, OFS_CTRL, 32'h3a2);
    k = irqs;
    // active-low gate: a high pin keeps the counter still
    u_tmr_pulse_src.drive(1'b1, 40);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(v, 32'h0);
    u_tmr_pulse_src.drive(1'b0, 60);
    u_tmr_pulse_src.drive(1'b1, 30);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(32'(v >= 2 && v <= 3), 32'h1);
    chk(32'(irqs - k), 32'h1);
  endtask : t_window

  task automatic final_report();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset_map();
    t_timer();
    t_event();
    t_ext();
    t_pulse();
    t_window();
    final_report();
  end

  // tests need about 7100 cycles
  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule : multimode_timer_counter16_tb_top
